/* core/usb_ep0_pkg.sv */
// Constants shared by the control endpoint buffer and stall logic.
package usb_ep0_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h04;
    localparam logic [7:0] OFS_IRQ_SELECT = 8'h08;
    localparam logic [7:0] OFS_TRIGGER = 8'h0C;
    localparam logic [7:0] OFS_FIFO_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IN_FIFO = 8'h14;
    localparam logic [7:0] OFS_OUT_FIFO = 8'h18;
    localparam logic [7:0] OFS_OUT_SIZE = 8'h1C;
    localparam logic [7:0] OFS_STALL_REQ = 8'h20;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int IRQ_SRC_N = 5;
    localparam int BIT_SOF = 4;
    localparam int BIT_SETUP = 3;
    localparam int BIT_OUT_DONE = 2;
    localparam int BIT_IN_REQ = 1;
    localparam int BIT_IN_DONE = 0;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [4:0] IRQ_FLAG_RESET = 5'h00;
    localparam logic [4:0] IRQ_SELECT_RESET = 5'h00;
    localparam int TRIG_IN_COMMIT = 0;
    localparam int TRIG_OUT_FINISH = 1;
    localparam int CLR_IN = 0;
    localparam int CLR_OUT = 1;

    // ------------------------------------------------------------------
    // Buffer sizing
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 5;
    localparam logic [PTR_W-1:0] PTR_FULL = 5'h10;
    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;

endpackage

/* core/usb_ep0_ram.sv */
// Small buffer memory with a registered read port.
`timescale 1ns/100ps
`default_nettype none

module usb_ep0_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic we, // Write strobe.
    input wire logic [AW-1:0] waddr, // Write address.
    input wire logic [WIDTH-1:0] wdata, // Write data.
    input wire logic [AW-1:0] raddr, // Read address, data one cycle later.
    output logic [WIDTH-1:0] rdata // Registered read data.
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } ram_state_type;

    ram_state_type s;
    ram_state_type next_s;

    always_comb begin
        next_s = s;
        if (we) begin
            next_s.mem[waddr] = wdata;
        end
        next_s.rdata = s.mem[raddr];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;

endmodule

`default_nettype wire

/* core/usb_ep0_core.sv */
// Control endpoint buffers, interrupt enables and stall handling behind APB.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module usb_ep0_core
    import usb_ep0_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int EP_W = (NUM_EP > 1) ? $clog2(NUM_EP) : 1
) (
    input wire logic pclk, // Clock, 125 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [ADDR_W-1:0] paddr, // APB byte address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic sof_seen, // Packet engine saw a start-of-frame.
    input wire logic setup_rcvd, // Packet engine received a setup command.
    input wire logic in_token_req, // Host asked for control IN data.
    input wire logic host_ack, // Host returned ACK to the IN packet.
    input wire logic tx_rd, // Engine takes one IN byte.
    output logic [7:0] tx_data, // IN byte at the read pointer.
    output logic tx_pending, // Committed IN bytes remain to send.
    output logic [PTR_W-1:0] tx_count, // Committed IN packet length.
    input wire logic rx_wr, // Engine delivers one OUT byte.
    input wire logic [7:0] rx_data, // OUT byte.
    input wire logic rx_end_ok, // OUT packet ended without error.
    input wire logic rx_end_err, // OUT packet ended with an error.
    output logic rx_ready, // OUT buffer can take bytes.
    input wire logic txn_valid, // Host transaction arrives.
    input wire logic [EP_W-1:0] txn_ep, // Endpoint of the transaction.
    input wire logic violation, // Host broke the protocol.
    input wire logic [EP_W-1:0] violation_ep, // Endpoint of the violation.
    input wire logic clear_feature, // Host Clear Feature for an endpoint.
    input wire logic [EP_W-1:0] clear_feature_ep, // Endpoint of the Clear Feature.
    output logic stall_reply, // Answer STALL to the transaction.
    output logic accept_reply, // Accept the transaction.
    output logic [1:0] irq_req // Interrupt request lines, by vector.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] irq_en;
        logic [IRQ_SRC_N-1:0] flags;
        logic [IRQ_SRC_N-1:0] vsel;
        logic [NUM_EP-1:0] stall_req;
        logic [NUM_EP-1:0] hidden;
        logic [PTR_W-1:0] in_wptr;
        logic [PTR_W-1:0] in_rptr;
        logic [PTR_W-1:0] in_cnt;
        logic in_commit;
        logic tx_pending;
        logic [PTR_W-1:0] out_wptr;
        logic [PTR_W-1:0] out_rptr;
        logic [PTR_W-1:0] out_size;
        logic out_full;
        logic rx_ready;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic stall_reply;
        logic accept_reply;
        logic [1:0] irq_req;
    } core_state_type;

    core_state_type s;
    core_state_type next_s;
    logic in_we;
    logic out_we;
    logic [7:0] in_rdata;
    logic [7:0] out_rdata;
    logic hit;
    logic done;
    logic wr;
    logic [IRQ_SRC_N-1:0] flag_set;
    logic [IRQ_SRC_N-1:0] flag_clr;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.stall_reply = 1'b0;
        next_s.accept_reply = 1'b0;
        hit = (paddr == OFS_IRQ_ENABLE) || (paddr == OFS_IRQ_FLAG)
            || (paddr == OFS_IRQ_SELECT) || (paddr == OFS_TRIGGER)
            || (paddr == OFS_FIFO_CLEAR) || (paddr == OFS_IN_FIFO)
            || (paddr == OFS_OUT_FIFO) || (paddr == OFS_OUT_SIZE)
            || (paddr == OFS_STALL_REQ);
        done = psel && penable && s.pready;
        wr = done && pwrite && hit;
        in_we = 1'b0;
        out_we = 1'b0;
        flag_set = '0;
        flag_clr = '0;

        // APB answers one cycle into the access phase, data from a flop.
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !hit;
            next_s.prdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    OFS_IRQ_ENABLE: next_s.prdata[7:0] = {3'b000, s.irq_en[4:0]};
                    OFS_IRQ_FLAG: next_s.prdata[IRQ_SRC_N-1:0] = s.flags;
                    OFS_IRQ_SELECT: next_s.prdata[IRQ_SRC_N-1:0] = s.vsel;
                    OFS_OUT_FIFO: next_s.prdata[7:0] = out_rdata;
                    OFS_OUT_SIZE: next_s.prdata[PTR_W-1:0] = s.out_size;
                    OFS_STALL_REQ: next_s.prdata[NUM_EP-1:0] = s.stall_req;
                    // The IN buffer is write only; it reads as zero.
                    default: next_s.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Control registers.
        if (wr && paddr == OFS_IRQ_ENABLE) begin
            next_s.irq_en = {3'b000, pwdata[4:0]};
        end
        if (wr && paddr == OFS_IRQ_SELECT) begin
            next_s.vsel = pwdata[IRQ_SRC_N-1:0];
        end
        if (wr && paddr == OFS_IRQ_FLAG) begin
            flag_clr = pwdata[IRQ_SRC_N-1:0];
        end
        if (wr && paddr == OFS_STALL_REQ) begin
            next_s.stall_req = pwdata[NUM_EP-1:0];
        end

        // IN buffer: filled by software, drained by the packet engine.
        if (wr && paddr == OFS_IN_FIFO && !s.in_commit && s.in_wptr != PTR_FULL) begin
            in_we = 1'b1;
            next_s.in_wptr = s.in_wptr + 5'h01;
        end
        if (wr && paddr == OFS_TRIGGER && pwdata[TRIG_IN_COMMIT] && !s.in_commit) begin
            next_s.in_commit = 1'b1;
            next_s.in_cnt = s.in_wptr;
            next_s.in_rptr = PTR_RESET;
        end
        if (tx_rd && s.tx_pending) begin
            next_s.in_rptr = s.in_rptr + 5'h01;
        end
        if (in_token_req) begin
            flag_set[BIT_IN_REQ] = 1'b1;
        end
        if (host_ack && s.in_commit) begin
            flag_set[BIT_IN_DONE] = 1'b1;
            next_s.in_commit = 1'b0;
            next_s.in_wptr = PTR_RESET;
            next_s.in_rptr = PTR_RESET;
        end
        if (wr && paddr == OFS_FIFO_CLEAR && pwdata[CLR_IN]) begin
            next_s.in_commit = 1'b0;
            next_s.in_wptr = PTR_RESET;
            next_s.in_rptr = PTR_RESET;
            next_s.in_cnt = PTR_RESET;
        end

        // OUT buffer: filled by the packet engine, drained by software.
        if (rx_wr && s.rx_ready) begin
            out_we = 1'b1;
            next_s.out_wptr = s.out_wptr + 5'h01;
        end
        if (rx_end_err && !s.out_full) begin
            next_s.out_wptr = PTR_RESET;
        end
        if (rx_end_ok && !s.out_full) begin
            flag_set[BIT_OUT_DONE] = 1'b1;
            next_s.out_size = (rx_wr && s.rx_ready) ? s.out_wptr + 5'h01 : s.out_wptr;
            next_s.out_full = 1'b1;
            next_s.out_rptr = PTR_RESET;
        end
        if (done && !pwrite && paddr == OFS_OUT_FIFO && s.out_rptr != s.out_wptr) begin
            next_s.out_rptr = s.out_rptr + 5'h01;
        end
        if (wr && paddr == OFS_TRIGGER && pwdata[TRIG_OUT_FINISH]) begin
            next_s.out_full = 1'b0;
            next_s.out_wptr = PTR_RESET;
            next_s.out_rptr = PTR_RESET;
        end
        if (wr && paddr == OFS_FIFO_CLEAR && pwdata[CLR_OUT]) begin
            next_s.out_full = 1'b0;
            next_s.out_wptr = PTR_RESET;
            next_s.out_rptr = PTR_RESET;
            next_s.out_size = PTR_RESET;
        end
        next_s.tx_pending = next_s.in_commit && (next_s.in_rptr != next_s.in_cnt);
        next_s.rx_ready = !next_s.out_full && (next_s.out_wptr != PTR_FULL);

        // Flags: a hardware set wins over a software clear in the same cycle.
        flag_set[BIT_SOF] = sof_seen;
        flag_set[BIT_SETUP] = setup_rcvd;
        next_s.flags = (s.flags & ~flag_clr) | flag_set;
        next_s.irq_req[0] = |(next_s.flags & next_s.irq_en[4:0] & ~next_s.vsel);
        next_s.irq_req[1] = |(next_s.flags & next_s.irq_en[4:0] & next_s.vsel);

        // Hidden stall bits: clears first, so a set in the same cycle wins.
        if (clear_feature) begin
            next_s.hidden[clear_feature_ep] = 1'b0;
        end
        if (setup_rcvd) begin
            next_s.hidden[0] = 1'b0;
        end
        if (violation) begin
            next_s.hidden[violation_ep] = 1'b1;
        end
        if (txn_valid) begin
            if (s.hidden[txn_ep] || s.stall_req[txn_ep]) begin
                next_s.hidden[txn_ep] = 1'b1;
                next_s.stall_reply = 1'b1;
            end else begin
                next_s.accept_reply = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.irq_en <= IRQ_ENABLE_RESET;
            s.flags <= IRQ_FLAG_RESET;
            s.vsel <= IRQ_SELECT_RESET;
            s.rx_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Buffer memories
    // ------------------------------------------------------------------
    usb_ep0_ram #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(PTR_W - 1)) in_ram (
        .clk(pclk),
        .rst_n(presetn),
        .we(in_we),
        .waddr(s.in_wptr[PTR_W-2:0]),
        .wdata(pwdata[7:0]),
        .raddr(next_s.in_rptr[PTR_W-2:0]),
        .rdata(in_rdata)
    );

    usb_ep0_ram #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(PTR_W - 1)) out_ram (
        .clk(pclk),
        .rst_n(presetn),
        .we(out_we),
        .waddr(s.out_wptr[PTR_W-2:0]),
        .wdata(rx_data),
        .raddr(next_s.out_rptr[PTR_W-2:0]),
        .rdata(out_rdata)
    );

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign tx_data = in_rdata;
    assign tx_pending = s.tx_pending;
    assign tx_count = s.in_cnt;
    assign rx_ready = s.rx_ready;
    assign stall_reply = s.stall_reply;
    assign accept_reply = s.accept_reply;
    assign irq_req = s.irq_req;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    irq_cause_a: assert property ((irq_req != 2'b00) |->
        ((s.flags & s.irq_en[4:0]) != '0))
        else $error("interrupt request without an enabled flag");
    vector_pick_a: assert property (irq_req[1] |-> ((s.flags & s.irq_en[4:0] & s.vsel) != '0))
        else $error("second request line without a selected source");
    enable_rsvd_a: assert property (wr && paddr == OFS_IRQ_ENABLE |=>
        s.irq_en == {3'b000, $past(pwdata[4:0])})
        else $error("enable register did not take its writable bits");
    reserved_zero_a: assert property (s.irq_en[7:5] == 3'b000)
        else $error("reserved enable bits not zero");
    in_ack_a: assert property ($rose(s.flags[BIT_IN_DONE]) |-> $past(host_ack && s.in_commit))
        else $error("IN done flag set without an ACK");
    in_clear_a: assert property (wr && paddr == OFS_FIFO_CLEAR && pwdata[CLR_IN] |=>
        s.in_wptr == PTR_RESET && !s.in_commit && !tx_pending)
        else $error("IN clear left data pending");
    out_size_a: assert property (rx_end_ok && !s.out_full && !rx_wr |=>
        s.flags[BIT_OUT_DONE] && s.out_size == $past(s.out_wptr) && !rx_ready)
        else $error("OUT completion did not flag and size");
    out_hold_a: assert property (s.out_full && !(wr && (paddr == OFS_TRIGGER
        || paddr == OFS_FIFO_CLEAR)) |=> s.out_full && !rx_ready)
        else $error("OUT buffer reopened without read finish");
    stall_set_a: assert property (txn_valid && !s.hidden[txn_ep] && s.stall_req[txn_ep] |=>
        stall_reply && !accept_reply && s.hidden[$past(txn_ep)])
        else $error("requested stall not answered");
    accept_a: assert property (txn_valid && !s.hidden[txn_ep] && !s.stall_req[txn_ep] |=>
        accept_reply && !stall_reply)
        else $error("clean transaction not accepted");
    hidden_hold_a: assert property (s.hidden[0] && !clear_feature && !setup_rcvd |=>
        s.hidden[0])
        else $error("endpoint 0 stall bit dropped without cause");
    setup_clr_a: assert property (setup_rcvd && !violation && !txn_valid |=> !s.hidden[0])
        else $error("setup did not clear the endpoint 0 stall bit");
    request_only_a: assert property ($changed(s.stall_req) && !$past(txn_valid)
        && !$past(violation) && !$past(clear_feature) && !$past(setup_rcvd)
        |-> $stable(s.hidden))
        else $error("stall request write changed a hidden bit");
    vector_low_a: assert property (irq_req[0] |-> ((s.flags & s.irq_en[4:0] & ~s.vsel) != '0))
        else $error("first request line without a selected source");
    in_refuse_a: assert property (wr && paddr == OFS_IN_FIFO && s.in_commit && !host_ack |=>
        $stable(s.in_wptr))
        else $error("IN buffer took a byte while committed");
    in_read_a: assert property (tx_rd && s.tx_pending && !host_ack
        && !(wr && paddr == OFS_FIFO_CLEAR) |=> s.in_rptr == $past(s.in_rptr) + 5'h01)
        else $error("IN read pointer did not advance by one");
    out_read_a: assert property (done && !pwrite && paddr == OFS_OUT_FIFO
        && s.out_rptr != s.out_wptr && !rx_end_ok |=> s.out_rptr == $past(s.out_rptr) + 5'h01)
        else $error("OUT read pointer did not advance by one");
    out_clear_a: assert property (wr && paddr == OFS_FIFO_CLEAR && pwdata[CLR_OUT] |=>
        !s.out_full && s.out_wptr == PTR_RESET && s.out_size == PTR_RESET)
        else $error("OUT clear left the buffer filled");
    rx_drop_a: assert property (rx_wr && !rx_ready && !rx_end_err && !wr |=>
        $stable(s.out_wptr))
        else $error("OUT byte taken while the buffer was closed");
    hidden_keep_a: assert property (!clear_feature && !setup_rcvd |=>
        (s.hidden & $past(s.hidden)) == $past(s.hidden))
        else $error("hidden stall bit dropped without Clear Feature");

    in_packet_c: cover property (host_ack && s.in_commit && s.in_cnt == PTR_FULL);
    out_packet_c: cover property (rx_end_ok && s.out_wptr == PTR_FULL);
    stall_c: cover property (stall_reply ##[1:20] accept_reply);
    flag_race_c: cover property (sof_seen && wr && paddr == OFS_IRQ_FLAG && pwdata[BIT_SOF]);
    in_refuse_c: cover property (wr && paddr == OFS_IN_FIFO && s.in_commit);

endmodule

`default_nettype wire

/* testbench/usb_host_model.sv */
// Host and packet engine model that drives the endpoint side of the block.
`timescale 1ns/100ps
`default_nettype none

module usb_host_model (
    input wire logic pclk, // Clock.
    output logic sof_seen, // Start-of-frame pulse.
    output logic setup_rcvd, // Setup command pulse.
    output logic in_token_req, // IN token pulse.
    output logic host_ack, // ACK pulse for the IN packet.
    output logic tx_rd, // Take one IN byte.
    output logic rx_wr, // OUT byte strobe.
    output logic [7:0] rx_data, // OUT byte.
    output logic rx_end_ok, // Good end of OUT packet.
    output logic rx_end_err, // Bad end of OUT packet.
    output logic txn_valid, // Transaction pulse.
    output logic violation, // Protocol violation pulse.
    output logic clear_feature, // Clear Feature pulse.
    output logic [1:0] ep, // Endpoint of the pulse.
    input wire logic stall_reply, // STALL answer.
    input wire logic accept_reply // Accept answer.
);
    initial begin
        {sof_seen, setup_rcvd, in_token_req, host_ack, tx_rd, rx_wr} = '0;
        {rx_end_ok, rx_end_err, txn_valid, violation, clear_feature} = '0;
        rx_data = 8'h5a;
        ep = 2'd0;
    end

    // Raises the line picked by kind for one cycle.
    task automatic pulse(input int kind, input logic [1:0] e, input logic [7:0] d);
        @(posedge pclk);
        ep <= e;
        rx_data <= d;
        case (kind)
            0: sof_seen <= 1'b1;
            1: setup_rcvd <= 1'b1;
            2: in_token_req <= 1'b1;
            3: host_ack <= 1'b1;
            4: tx_rd <= 1'b1;
            5: rx_wr <= 1'b1;
            6: rx_end_ok <= 1'b1;
            7: txn_valid <= 1'b1;
            8: violation <= 1'b1;
            9: clear_feature <= 1'b1;
            default: rx_end_err <= 1'b1;
        endcase
        @(posedge pclk);
        {sof_seen, setup_rcvd, in_token_req, host_ack, tx_rd, rx_wr} <= '0;
        {rx_end_ok, rx_end_err, txn_valid, violation, clear_feature} <= '0;
        // A released data line must not keep showing the last byte.
        rx_data <= ~d;
        ep <= ~e;
    endtask

    // Sends a transaction and returns the answer of the next cycle.
    task automatic txn(input logic [1:0] e, output logic st, output logic ac);
        pulse(7, e, 8'h00);
        @(negedge pclk);
        st = stall_reply;
        ac = accept_reply;
    endtask
endmodule

`default_nettype wire

/* testbench/test_usb_ep0_buffers_and_stall.sv */
// Self-checking bench for the control endpoint buffers and stall logic.
`timescale 1ns/100ps
`default_nettype none

module test_usb_ep0_buffers_and_stall
    import usb_ep0_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, tx_data, rx_data;
    logic [31:0] pwdata, prdata;
    logic sof_seen, setup_rcvd, in_token_req, host_ack, tx_rd, tx_pending, rx_wr;
    logic rx_end_ok, rx_end_err, rx_ready, txn_valid, violation, clear_feature;
    logic stall_reply, accept_reply;
    logic [1:0] ep, irq_req;
    logic [PTR_W-1:0] tx_count;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    usb_ep0_core #(.NUM_EP(4)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .sof_seen, .setup_rcvd, .in_token_req,
        .host_ack, .tx_rd, .tx_data, .tx_pending, .tx_count, .rx_wr, .rx_data,
        .rx_end_ok, .rx_end_err, .rx_ready, .txn_valid, .txn_ep(ep), .violation,
        .violation_ep(ep), .clear_feature, .clear_feature_ep(ep), .stall_reply,
        .accept_reply, .irq_req);

    usb_host_model host (.pclk, .sof_seen, .setup_rcvd, .in_token_req, .host_ack,
        .tx_rd, .rx_wr, .rx_data, .rx_end_ok, .rx_end_err, .txn_valid, .violation,
        .clear_feature, .ep, .stall_reply, .accept_reply);

    always #4 pclk = ~pclk;

    task automatic end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, r, x);
    endtask

    // Lets registered outputs land, then samples mid-cycle.
    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rdc("enable", OFS_IRQ_ENABLE, 32'h0000_0000);
        wr(OFS_IRQ_ENABLE, 32'h0000_001f);
        rdc("enable", OFS_IRQ_ENABLE, 32'h0000_001f);
        apb(1'b1, 8'hfc, 32'h0000_00ff, r, e);
        chk("unmapped", 32'(e), 32'h0000_0001);
    endtask

    task automatic t_irq();
        host.pulse(0, 2'd0, 8'h00);
        host.pulse(1, 2'd0, 8'h00);
        host.pulse(2, 2'd0, 8'h00);
        rdc("flags", OFS_IRQ_FLAG, 32'h0000_001a);
        settle();
        chk("irq", 32'(irq_req), 32'h0000_0001);
        wr(OFS_IRQ_SELECT, 32'h0000_0008);
        settle();
        chk("irq", 32'(irq_req), 32'h0000_0003);
        wr(OFS_IRQ_ENABLE, 32'h0000_0008);
        settle();
        chk("irq", 32'(irq_req), 32'h0000_0002);
        wr(OFS_IRQ_FLAG, 32'h0000_001f);
        settle();
        chk("irq", 32'(irq_req), 32'h0000_0000);
        wr(OFS_IRQ_ENABLE, 32'h0000_001f);
    endtask

    task automatic t_in();
        logic [7:0] b [3] = '{8'ha1, 8'hb2, 8'hc3};
        for (int i = 0; i < 3; i++) wr(OFS_IN_FIFO, 32'(b[i]));
        wr(OFS_TRIGGER, 32'h0000_0001);
        settle();
        chk("in count", 32'(tx_count), 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            chk("in pending", 32'(tx_pending), 32'h0000_0001);
            chk("in byte", 32'(tx_data), 32'(b[i]));
            host.pulse(4, 2'd0, 8'h00);
            settle();
        end
        chk("in pending", 32'(tx_pending), 32'h0000_0000);
        rdc("flags", OFS_IRQ_FLAG, 32'h0000_0000);
        host.pulse(3, 2'd0, 8'h00);
        rdc("flags", OFS_IRQ_FLAG, 32'h0000_0001);
        wr(OFS_IRQ_FLAG, 32'h0000_0001);
        wr(OFS_IN_FIFO, 32'h0000_0011);
        wr(OFS_IN_FIFO, 32'h0000_0022);
        wr(OFS_FIFO_CLEAR, 32'h0000_0001);
        wr(OFS_IN_FIFO, 32'h0000_005a);
        wr(OFS_TRIGGER, 32'h0000_0001);
        wr(OFS_IN_FIFO, 32'h0000_0077);
        settle();
        chk("in count", 32'(tx_count), 32'h0000_0001);
        chk("in byte", 32'(tx_data), 32'h0000_005a);
        host.pulse(4, 2'd0, 8'h00);
        host.pulse(3, 2'd0, 8'h00);
        wr(OFS_IRQ_FLAG, 32'h0000_0001);
    endtask

    task automatic t_out();
        chk("out ready", 32'(rx_ready), 32'h0000_0001);
        host.pulse(5, 2'd0, 8'h11);
        host.pulse(5, 2'd0, 8'h22);
        host.pulse(6, 2'd0, 8'h00);
        settle();
        chk("out ready", 32'(rx_ready), 32'h0000_0000);
        host.pulse(5, 2'd0, 8'h33);
        rdc("flags", OFS_IRQ_FLAG, 32'h0000_0004);
        rdc("out size", OFS_OUT_SIZE, 32'h0000_0002);
        rdc("out byte", OFS_OUT_FIFO, 32'h0000_0011);
        rdc("out byte", OFS_OUT_FIFO, 32'h0000_0022);
        wr(OFS_TRIGGER, 32'h0000_0002);
        settle();
        chk("out ready", 32'(rx_ready), 32'h0000_0001);
        host.pulse(5, 2'd0, 8'h44);
        wr(OFS_FIFO_CLEAR, 32'h0000_0002);
        host.pulse(5, 2'd0, 8'h55);
        host.pulse(6, 2'd0, 8'h00);
        rdc("out size", OFS_OUT_SIZE, 32'h0000_0001);
        rdc("out byte", OFS_OUT_FIFO, 32'h0000_0055);
        wr(OFS_TRIGGER, 32'h0000_0002);
    endtask

    task automatic tx(input logic [1:0] e, input logic s);
        logic st, ac;
        host.txn(e, st, ac);
        chk("stall reply", 32'(st), 32'(s));
        chk("accept reply", 32'(ac), 32'(!s));
    endtask

    task automatic t_stall();
        tx(2'd1, 1'b0);
        wr(OFS_STALL_REQ, 32'h0000_0008);
        wr(OFS_STALL_REQ, 32'h0000_0000);
        tx(2'd3, 1'b0);
        wr(OFS_STALL_REQ, 32'h0000_0002);
        tx(2'd1, 1'b1);
        wr(OFS_STALL_REQ, 32'h0000_0000);
        tx(2'd1, 1'b1);
        host.pulse(9, 2'd1, 8'h00);
        tx(2'd1, 1'b0);
        host.pulse(8, 2'd2, 8'h00);
        tx(2'd2, 1'b1);
        tx(2'd3, 1'b0);
        wr(OFS_STALL_REQ, 32'h0000_0001);
        tx(2'd0, 1'b1);
        wr(OFS_STALL_REQ, 32'h0000_0000);
        host.pulse(1, 2'd0, 8'h00);
        tx(2'd0, 1'b0);
        tx(2'd2, 1'b1);
        host.pulse(9, 2'd2, 8'h00);
        tx(2'd2, 1'b0);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_in();
        t_out();
        t_stall();
        end_sim();
    end
endmodule

`default_nettype wire
